// [src/ioadm_pkg.sv]
package ioadm_pkg;
    // register indices of the low i/o bank; the apb byte address is four times the index
    localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
    localparam logic [7:0] IDX_PORT_A_DIR  = 8'h04;
    localparam logic [7:0] IDX_PORT_B_DIR  = 8'h05;
    localparam logic [7:0] IDX_IRQ_KBD     = 8'h1a;
    localparam logic [7:0] IDX_KBD_ENABLE  = 8'h1b;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h30;
    localparam logic [7:0] IDX_INT_ENABLE  = 8'h31;
    localparam logic [7:0] IDX_INT_CLEAR   = 8'h32;
    localparam logic [7:0] IDX_LAST_ADDR   = 8'h33;
    // cpu-side memory map boundaries
    localparam logic [15:0] MAP_IO_LO     = 16'h0000;
    localparam logic [15:0] MAP_IO_HI     = 16'h003f;
    localparam logic [15:0] MAP_RAM_LO    = 16'h0080;
    localparam logic [15:0] MAP_RAM_HI    = 16'h00ff;
    localparam logic [15:0] MAP_FLASH_LO  = 16'h7800;
    localparam logic [15:0] MAP_FLASH_HI  = 16'h7fee;
    localparam logic [15:0] MAP_TRIM      = 16'h7fef;
    localparam logic [15:0] MAP_VEC_LO    = 16'hfff2;
    localparam logic [15:0] MAP_VEC_HI    = 16'hffff;
    localparam logic [15:0] MAP_MON_LO    = 16'hf000;
    localparam logic [15:0] MAP_MON_HI    = 16'hf2ef;
    localparam logic [15:0] MAP_SYS_LO    = 16'hfe00;
    localparam logic [15:0] MAP_SYS_B     = 16'hfe08;
    localparam logic [15:0] MAP_SYS_C_LO  = 16'hfe0c;
    localparam logic [15:0] MAP_SYS_C_HI  = 16'hfe0f;
    localparam logic [15:0] MAP_RSV_LO    = 16'hfe03;
    localparam logic [15:0] MAP_RSV_HI    = 16'hfe06;
    localparam logic [15:0] MAP_RSV_B     = 16'hfe09;
    localparam logic [15:0] MAP_PROTECT   = 16'hfff0;
    localparam logic [15:0] MAP_WATCHDOG  = 16'hffff;
    // field positions
    localparam int BIT_MCLK_OUT_EN = 7;
    localparam int BIT_IRQ_FLAG    = 7;
    localparam int BIT_IRQ_ACK     = 6;
    localparam int BIT_IRQ_MASK    = 5;
    localparam int BIT_IRQ_MODE    = 4;
    localparam int BIT_KBD_FLAG    = 3;
    localparam int BIT_KBD_ACK     = 2;
    localparam int BIT_KBD_MASK    = 1;
    localparam int BIT_KBD_MODE    = 0;
    localparam logic [7:0] PORT_B_MASK   = 8'h3f;
    localparam logic [7:0] DIR_B_MASK    = 8'hbf;
    localparam logic [7:0] KBD_EN_MASK   = 8'h7e;
    localparam logic [7:0] CTRL_WR_MASK  = 8'h33;
    localparam logic [7:0] RESET_ZERO    = 8'h00;
    // interrupt status bits
    localparam int EV_ILLEGAL = 0;
    localparam int EV_IRQ     = 1;
    localparam int EV_KBD     = 2;
    localparam int EV_W       = 3;
    // decoded region of a cpu access
    typedef enum logic [3:0] {
        IOADM_SEL_NONE   = 4'b0000,
        IOADM_SEL_IO     = 4'b0001,
        IOADM_SEL_RAM    = 4'b0010,
        IOADM_SEL_FLASH  = 4'b0011,
        IOADM_SEL_TRIM   = 4'b0100,
        IOADM_SEL_VECTOR = 4'b0101,
        IOADM_SEL_MON    = 4'b0110,
        IOADM_SEL_SYSREG = 4'b0111,
        IOADM_SEL_RSVD   = 4'b1000
    } ioadm_sel_t;
endpackage

// [src/ioadm_top.sv]
//Contract
// - unimplemented access requests illegal-address reset
// - route 0000-003f to i/o registers
// - map 128-byte ram at 0080-00ff
// - map 2031-byte flash at 7800-7fee
// - fourteen vector bytes at top of map, fff2-ffff; ffff decodes as the watchdog register
// - map monitor rom f000-f2ef
// - reserve 7fef for clock trim value
// - select system registers fe00 up to ffff; only fe00-fe02, fe08, fe0c-fe0f, fff0 and ffff decode as such
// - port a data eight bits, reset-unaffected
// - port b data bits 5-0, reset-unaffected
// - port b six-bit bidirectional port
// - port a direction, cleared by reset
// - port b direction with clock-out enable
// - irq/keyboard control with flags and acks
// - enabled keyboard pins interrupt, pull up
// - internal reset drives reset pin low
//
// Our own choice: the APB register port.
module ioadm_top (
    input  wire logic                 SYS_CLK,
    input  wire logic                 SRST,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic                      PREADY,
    output logic [31:0]               PRDATA,
    output logic                      PSLVERR,
    input  wire logic                 CPU_VALID,
    input  wire logic [15:0]          CPU_ADDR,
    output ioadm_pkg::ioadm_sel_t     CPU_SEL,
    output logic                      ILLEGAL_RESET_REQ,
    input  wire logic [7:0]           PORT_A_IN,
    output logic [7:0]                PORT_A_OUT,
    output logic [7:0]                PORT_A_OE,
    output logic [7:0]                PORT_A_PULLUP,
    input  wire logic [5:0]           PORT_B_IN,
    output logic [5:0]                PORT_B_OUT,
    output logic [5:0]                PORT_B_OE,
    output logic                      MASTER_CLOCK_OUT_ENABLE,
    input  wire logic                 IRQ_PIN_N,
    output logic                      CPU_IRQ,
    output logic                      CPU_KBD_IRQ,
    input  wire logic                 INTERNAL_RESET,
    output logic                      RESET_PIN_N_OUT,
    output logic                      RESET_PIN_OE,
    output logic                      INT_OUT
);
    import ioadm_pkg::*;

    // register and pipeline state;
    // port data latches have no
    // reset, so software can preload
    // a value before a pin turns to
    // output without a glitch
    logic [7:0]  port_a_data_q, port_b_data_q, port_a_dir_q, port_b_dir_q;
    logic [7:0]  irq_keyboard_control_q, keyboard_enable_reg_q;
    logic [EV_W-1:0] int_status_q, int_enable_q;
    logic [15:0] last_addr_q;
    logic [7:0]  pa_s1_q, pa_s2_q, pa_s3_q;
    logic [5:0]  pb_s1_q, pb_s2_q;
    logic        irq_s1_q, irq_s2_q, irq_s3_q;
    logic        illegal_q;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q;
    ioadm_sel_t  sel_q;

    // cpu side: every valid cycle
    // is decoded at once and the
    // region is registered, so the
    // select lags the access by one
    // edge, just like the reset
    // request that a gap raises

    // cpu address decode, regions are disjoint except at ffff
    wire in_io    = (CPU_ADDR <= MAP_IO_HI);
    wire in_ram   = (CPU_ADDR >= MAP_RAM_LO) && (CPU_ADDR <= MAP_RAM_HI);
    wire in_flash = (CPU_ADDR >= MAP_FLASH_LO) && (CPU_ADDR <= MAP_FLASH_HI);
    wire in_trim  = (CPU_ADDR == MAP_TRIM);
    wire in_vec   = (CPU_ADDR >= MAP_VEC_LO) && (CPU_ADDR <= MAP_VEC_HI);
    wire in_mon   = (CPU_ADDR >= MAP_MON_LO) && (CPU_ADDR <= MAP_MON_HI);
    wire in_sys   = (CPU_ADDR >= MAP_SYS_LO && CPU_ADDR <= MAP_SYS_LO + 16'h2)
                 || (CPU_ADDR == MAP_SYS_B)
                 || (CPU_ADDR >= MAP_SYS_C_LO && CPU_ADDR <= MAP_SYS_C_HI)
                 || (CPU_ADDR == MAP_PROTECT) || (CPU_ADDR == MAP_WATCHDOG);
    // reserved and unimplemented
    // bytes differ: a stray access
    // to a reserved byte must not
    // reset the part, a gap must
    // reserved locations answer nothing defined but do not reset
    wire in_rsvd  = (CPU_ADDR >= MAP_RSV_LO && CPU_ADDR <= MAP_RSV_HI)
                 || (CPU_ADDR == MAP_RSV_B);
    // the select order matters only
    // at ffff, which is vector space
    // and the watchdog at once; the
    // register wins so writes land
    // vectors sit at the top of the map; watchdog wins ffff as a register
    wire        any_hit = in_io | in_ram | in_flash | in_trim | in_vec | in_mon | in_sys | in_rsvd;
    ioadm_sel_t sel_d;
    assign sel_d = !CPU_VALID ? IOADM_SEL_NONE :
                   in_sys     ? IOADM_SEL_SYSREG :
                   in_io      ? IOADM_SEL_IO :
                   in_ram     ? IOADM_SEL_RAM :
                   in_flash   ? IOADM_SEL_FLASH :
                   in_trim    ? IOADM_SEL_TRIM :
                   in_vec     ? IOADM_SEL_VECTOR :
                   in_mon     ? IOADM_SEL_MON :
                   in_rsvd    ? IOADM_SEL_RSVD : IOADM_SEL_NONE;
    wire illegal_hit = CPU_VALID && !any_hit;

    // register bus side: one register
    // per aligned word, one byte wide
    // save the two-byte last address,
    // in the low lanes; an address with
    // low bits set or no register
    // behind it answers with an
    // error and changes nothing

    // apb decode; a request is taken in its first access cycle
    wire apb_go = PSEL && PENABLE && !pready_q;
    wire wr     = apb_go && PWRITE;
    wire rd     = apb_go && !PWRITE;
    // misaligned addresses map to an index no register has
    wire [7:0] reg_idx = (PADDR[1:0] == 2'b00) ? {2'b00, PADDR[7:2]} : 8'hff;
    wire a_pa   = (reg_idx == IDX_PORT_A_DATA);
    wire a_pb   = (reg_idx == IDX_PORT_B_DATA);
    wire a_da   = (reg_idx == IDX_PORT_A_DIR);
    wire a_db   = (reg_idx == IDX_PORT_B_DIR);
    wire a_ik   = (reg_idx == IDX_IRQ_KBD);
    wire a_ke   = (reg_idx == IDX_KBD_ENABLE);
    wire a_st   = (reg_idx == IDX_INT_STATUS);
    wire a_en   = (reg_idx == IDX_INT_ENABLE);
    wire a_cl   = (reg_idx == IDX_INT_CLEAR);
    wire a_la   = (reg_idx == IDX_LAST_ADDR);
    wire mapped = a_pa | a_pb | a_da | a_db | a_ik | a_ke | a_st | a_en | a_cl | a_la;
    wire [7:0] wbyte = PWDATA[7:0];

    // a read of a port shows the
    // pin where the bit is an input,
    // so software sees what the
    // outside world drives there;
    // unused bits always read zero

    // pins read back where they are inputs, latch where outputs
    wire [7:0] pa_view = (port_a_dir_q & port_a_data_q) | (~port_a_dir_q & pa_s2_q);
    wire [5:0] pb_view = (port_b_dir_q[5:0] & port_b_data_q[5:0])
                       | (~port_b_dir_q[5:0] & pb_s2_q);
    wire [7:0] rmux =
        a_pa ? pa_view :
        a_pb ? {2'b00, pb_view} :
        a_da ? port_a_dir_q :
        a_db ? (port_b_dir_q & DIR_B_MASK) :
        a_ik ? (irq_keyboard_control_q & ~8'h44) :
        a_ke ? (keyboard_enable_reg_q & KBD_EN_MASK) :
        a_st ? {5'h00, int_status_q} :
        a_en ? {5'h00, int_enable_q} : 8'h00;
    wire [31:0] rword = a_la ? {16'h0000, last_addr_q} : {24'h000000, rmux};

    // keyboard and irq detection;
    // edge mode needs one cycle of
    // history, taken from the third
    // stage so no unsynchronised
    // value reaches the flag logic;
    // a disabled pin never counts

    // keyboard: enabled port a pins 6..1, active low, edge or level
    wire [7:0] kb_en   = keyboard_enable_reg_q & KBD_EN_MASK;
    wire       kb_any  = |(kb_en & ~pa_s2_q);
    wire       kb_was  = |(kb_en & ~pa_s3_q);
    wire       kb_ev   = irq_keyboard_control_q[BIT_KBD_MODE] ? kb_any : (kb_any && !kb_was);
    wire       irq_ev  = irq_keyboard_control_q[BIT_IRQ_MODE] ? !irq_s2_q : (!irq_s2_q && irq_s3_q);
    wire       ack_i   = wr && a_ik && wbyte[BIT_IRQ_ACK];
    wire       ack_k   = wr && a_ik && wbyte[BIT_KBD_ACK];
    wire [EV_W-1:0] ev = {kb_ev, irq_ev, illegal_hit};
    wire [EV_W-1:0] clr = (wr && a_cl) ? wbyte[EV_W-1:0] : '0;

    // pins are asynchronous: two
    // flops settle metastability
    // before anything reads them;
    // the cost is two cycles of lag
    // on every pin event

    // pin synchronisers; second stage feeds logic, third is an edge history
    always_ff @(posedge SYS_CLK) begin
        pa_s1_q  <= PORT_A_IN;
        pa_s2_q  <= pa_s1_q;
        pa_s3_q  <= pa_s2_q;
        pb_s1_q  <= PORT_B_IN;
        pb_s2_q  <= pb_s1_q;
        irq_s1_q <= IRQ_PIN_N;
        irq_s2_q <= irq_s1_q;
        irq_s3_q <= irq_s2_q;
    end

    // no reset branch on purpose:
    // the latches keep what was
    // written across every reset,
    // and power up unknown until
    // software writes them once

    // port data latches keep their content across reset
    always_ff @(posedge SYS_CLK) begin
        if (wr && a_pa) begin
            port_a_data_q <= wbyte;
        end
        if (wr && a_pb) begin
            port_b_data_q <= wbyte & PORT_B_MASK;
        end
    end

    // reset clears all of these so
    // every pin comes up as input
    // and of the interrupts only the
    // irq pin is armed after reset;
    // status is sticky until cleared

    // direction, control and interrupt registers
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            port_a_dir_q           <= RESET_ZERO;
            port_b_dir_q           <= RESET_ZERO;
            irq_keyboard_control_q <= RESET_ZERO;
            keyboard_enable_reg_q  <= RESET_ZERO;
            int_status_q           <= '0;
            int_enable_q           <= '0;
        end else begin
            if (wr && a_da) port_a_dir_q <= wbyte;
            if (wr && a_db) port_b_dir_q <= wbyte & DIR_B_MASK;
            if (wr && a_ke) keyboard_enable_reg_q <= wbyte & KBD_EN_MASK;
            if (wr && a_en) int_enable_q <= wbyte[EV_W-1:0];
            if (wr && a_ik) begin
                irq_keyboard_control_q[BIT_IRQ_MASK] <= wbyte[BIT_IRQ_MASK];
                irq_keyboard_control_q[BIT_IRQ_MODE] <= wbyte[BIT_IRQ_MODE];
                irq_keyboard_control_q[BIT_KBD_MASK] <= wbyte[BIT_KBD_MASK];
                irq_keyboard_control_q[BIT_KBD_MODE] <= wbyte[BIT_KBD_MODE];
            end
            // acknowledges are strobes:
            // they never store and read
            // back as zero, so only the
            // flag, mask and mode bits remain
            // flags: a new event wins over an acknowledge in the same cycle
            irq_keyboard_control_q[BIT_IRQ_FLAG] <= irq_ev | (irq_keyboard_control_q[BIT_IRQ_FLAG] & ~ack_i);
            irq_keyboard_control_q[BIT_KBD_FLAG] <= kb_ev | (irq_keyboard_control_q[BIT_KBD_FLAG] & ~ack_k);
            int_status_q <= ev | (int_status_q & ~clr);
        end
    end

    // the request must not fall
    // back before the reset
    // controller acts, or the
    // offending access would run
    // on with a bad address

    // illegal request holds until reset takes the device
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            illegal_q   <= 1'b0;
            last_addr_q <= 16'h0000;
            sel_q       <= IOADM_SEL_NONE;
        end else begin
            sel_q <= sel_d;
            if (illegal_hit) begin
                illegal_q   <= 1'b1;
                last_addr_q <= CPU_ADDR;
            end
        end
    end

    // ready is registered: one
    // wait cycle always, and it
    // clears itself so a request
    // still held is not taken twice;
    // read data stands with ready

    // apb answer registers, one wait state
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= PSEL && PENABLE && !pready_q;
            pslverr_q <= apb_go && !mapped;
            prdata_q  <= (rd && mapped) ? rword : 32'h00000000;
        end
    end

    // every pin control is a flop
    // so no decode glitch reaches
    // a pad; keyboard pins stop
    // driving so the pull-up works
    // and the key can pull low

    // pin drive registers; pull-ups follow the keyboard enables
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PORT_A_OUT              <= 8'h00;
            PORT_A_OE               <= 8'h00;
            PORT_A_PULLUP           <= 8'h00;
            PORT_B_OUT              <= 6'h00;
            PORT_B_OE               <= 6'h00;
            MASTER_CLOCK_OUT_ENABLE <= 1'b0;
            CPU_IRQ                 <= 1'b0;
            CPU_KBD_IRQ             <= 1'b0;
            INT_OUT                 <= 1'b0;
        end else begin
            PORT_A_OUT              <= port_a_data_q;
            PORT_A_OE               <= port_a_dir_q & ~kb_en;
            PORT_A_PULLUP           <= kb_en;
            PORT_B_OUT              <= port_b_data_q[5:0];
            PORT_B_OE               <= port_b_dir_q[5:0];
            MASTER_CLOCK_OUT_ENABLE <= port_b_dir_q[BIT_MCLK_OUT_EN];
            CPU_IRQ     <= irq_keyboard_control_q[BIT_IRQ_FLAG] & ~irq_keyboard_control_q[BIT_IRQ_MASK];
            CPU_KBD_IRQ <= irq_keyboard_control_q[BIT_KBD_FLAG] & ~irq_keyboard_control_q[BIT_KBD_MASK];
            INT_OUT     <= |(int_status_q & int_enable_q);
        end
    end

    // the pin only ever pulls low;
    // the outside pull-up raises it,
    // so other devices may share
    // the reset line safely; the
    // request path adds one edge

    // reset pin is driven during reset too, so it pulls low throughout
    always_ff @(posedge SYS_CLK) begin
        RESET_PIN_N_OUT <= 1'b0;
        RESET_PIN_OE    <= SRST | INTERNAL_RESET | illegal_q | illegal_hit;
    end

    // bus answers and decode
    // results leave straight from
    // their registers, so nothing
    // combinational reaches a port
    assign PREADY            = pready_q;
    assign PRDATA            = prdata_q;
    assign PSLVERR           = pslverr_q;
    assign CPU_SEL           = sel_q;
    assign ILLEGAL_RESET_REQ = illegal_q;
endmodule

// [testbench/ioadm_cpu_model.sv]
module ioadm_cpu_model (
    input wire logic    clk,
    output logic        cpu_valid,
    output logic [15:0] cpu_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cpu_valid = 1'b0;
        cpu_addr  = 16'hffff;
    end
    // one access, optionally after idle cycles, none for fe03-fe06; idle address is inverted so stale values never pass
    task automatic access(input logic [15:0] a, input int idle);
        if (a inside {[16'hfe03:16'hfe06]}) return;
        repeat (idle) @(posedge clk);
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_addr  <= a;
        @(posedge clk);
        cpu_valid <= 1'b0;
        cpu_addr  <= ~a;
    endtask
endmodule

// [testbench/ioadm_properties.sv]
module ioadm_checker (
    input wire logic          SYS_CLK,
    input wire logic          SRST,
    input wire logic          PSEL,
    input wire logic          PENABLE,
    input wire logic          PREADY,
    input wire logic          CPU_VALID,
    input wire logic [15:0]   CPU_ADDR,
    input ioadm_pkg::ioadm_sel_t CPU_SEL,
    input wire logic          ILLEGAL_RESET_REQ,
    input wire logic          INTERNAL_RESET,
    input wire logic          RESET_PIN_OE,
    input wire logic          RESET_PIN_N_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    import ioadm_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // live access per region; the gaps are where a reset request is owed
    wire in_io  = CPU_VALID && CPU_ADDR <= MAP_IO_HI;
    wire in_ram = CPU_VALID && CPU_ADDR inside {[MAP_RAM_LO:MAP_RAM_HI]};
    wire in_fl  = CPU_VALID && CPU_ADDR inside {[MAP_FLASH_LO:MAP_FLASH_HI]};
    wire in_tr  = CPU_VALID && CPU_ADDR == MAP_TRIM;
    wire in_vec = CPU_VALID && CPU_ADDR inside {[MAP_VEC_LO:16'hfffe]};
    wire in_mon = CPU_VALID && CPU_ADDR inside {[MAP_MON_LO:MAP_MON_HI]};
    wire in_sys = CPU_VALID && CPU_ADDR inside {MAP_SYS_LO, MAP_SYS_B, MAP_PROTECT, MAP_WATCHDOG};
    wire in_gap = CPU_VALID && CPU_ADDR inside {[16'h0040:16'h007f], [16'h0100:16'h77ff],
                                                [16'h7ff0:16'hefff], [16'hf2f0:16'hfdff], 16'hfe07,
                                                [16'hfe0a:16'hfe0b]};
    AST_SEL_IO: assert property (in_io |=> CPU_SEL == IOADM_SEL_IO)
        else $error("io region not selected");
    AST_SEL_RAM: assert property (in_ram |=> CPU_SEL == IOADM_SEL_RAM)
        else $error("ram not selected");
    AST_SEL_FLASH: assert property (in_fl |=> CPU_SEL == IOADM_SEL_FLASH)
        else $error("flash not selected");
    AST_SEL_VEC: assert property (in_vec |=> CPU_SEL == IOADM_SEL_VECTOR)
        else $error("vector not selected");
    AST_SEL_MON: assert property (in_mon |=> CPU_SEL == IOADM_SEL_MON)
        else $error("monitor rom not selected");
    AST_SEL_TRIM: assert property (in_tr |=> CPU_SEL == IOADM_SEL_TRIM)
        else $error("trim byte not selected");
    AST_SEL_SYS: assert property (in_sys |=> CPU_SEL == IOADM_SEL_SYSREG)
        else $error("system register not selected");
    AST_ILL_SET: assert property (in_gap |=> ILLEGAL_RESET_REQ && CPU_SEL == IOADM_SEL_NONE)
        else $error("gap access gave no reset request");
    AST_ILL_HOLD: assert property (ILLEGAL_RESET_REQ |=> ILLEGAL_RESET_REQ)
        else $error("reset request dropped before reset");
    AST_RST_PIN: assert property (ILLEGAL_RESET_REQ |-> RESET_PIN_OE && !RESET_PIN_N_OUT)
        else $error("reset pin not pulled low");
    AST_INT_RST: assert property (INTERNAL_RESET |=> RESET_PIN_OE)
        else $error("internal reset not on pin");
    AST_APB_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after one wait");
endmodule

bind ioadm_top ioadm_checker u_ioadm_checker (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .CPU_VALID(CPU_VALID), .CPU_ADDR(CPU_ADDR), .CPU_SEL(CPU_SEL), .ILLEGAL_RESET_REQ(ILLEGAL_RESET_REQ),
    .INTERNAL_RESET(INTERNAL_RESET), .RESET_PIN_OE(RESET_PIN_OE), .RESET_PIN_N_OUT(RESET_PIN_N_OUT)
);

// [testbench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ioadm_pkg::*;
    logic        SYS_CLK, SRST, PSEL, PENABLE, PWRITE, IRQ_PIN_N, INTERNAL_RESET, err;
    logic [7:0]  PADDR, PORT_A_IN;
    logic [31:0] PWDATA, rd;
    logic [5:0]  PORT_B_IN;
    logic        CPU_VALID;
    logic [15:0] CPU_ADDR;
    wire         PREADY, PSLVERR, ILLEGAL_RESET_REQ, MASTER_CLOCK_OUT_ENABLE, CPU_IRQ, CPU_KBD_IRQ;
    wire         RESET_PIN_N_OUT, RESET_PIN_OE, INT_OUT;
    wire [31:0]  PRDATA;
    wire [7:0]   PORT_A_OUT, PORT_A_OE, PORT_A_PULLUP;
    wire [5:0]   PORT_B_OUT, PORT_B_OE;
    ioadm_sel_t  CPU_SEL;
    int          err_count, checks_done, cycles;
    logic [15:0] ok_addr [15] = '{16'h0000, 16'h003f, 16'h0080, 16'h00ff, 16'h7800, 16'h7fee, 16'h7fef,
                                  16'hf000, 16'hf2ef, 16'hfe00, 16'hfe08, 16'hfff0, 16'hfff2, 16'hfffe, 16'hffff};
    ioadm_sel_t  ok_sel [15] = '{IOADM_SEL_IO, IOADM_SEL_IO, IOADM_SEL_RAM, IOADM_SEL_RAM, IOADM_SEL_FLASH,
                                 IOADM_SEL_FLASH, IOADM_SEL_TRIM, IOADM_SEL_MON, IOADM_SEL_MON, IOADM_SEL_SYSREG,
                                 IOADM_SEL_SYSREG, IOADM_SEL_SYSREG, IOADM_SEL_VECTOR, IOADM_SEL_VECTOR, IOADM_SEL_SYSREG};
    logic [15:0] bad_addr [5] = '{16'h0040, 16'h0100, 16'h7ff0, 16'hf2f0, 16'hfe07};
    logic [7:0]  zero_reg [6] = '{IDX_PORT_A_DIR, IDX_PORT_B_DIR, IDX_IRQ_KBD, IDX_KBD_ENABLE, IDX_INT_STATUS,
                                  IDX_INT_ENABLE};
    ioadm_top u_ioadm_top (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CPU_VALID(CPU_VALID),
        .CPU_ADDR(CPU_ADDR), .CPU_SEL(CPU_SEL), .ILLEGAL_RESET_REQ(ILLEGAL_RESET_REQ), .PORT_A_IN(PORT_A_IN),
        .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE(PORT_A_OE), .PORT_A_PULLUP(PORT_A_PULLUP), .PORT_B_IN(PORT_B_IN),
        .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE(PORT_B_OE), .MASTER_CLOCK_OUT_ENABLE(MASTER_CLOCK_OUT_ENABLE),
        .IRQ_PIN_N(IRQ_PIN_N), .CPU_IRQ(CPU_IRQ), .CPU_KBD_IRQ(CPU_KBD_IRQ), .INTERNAL_RESET(INTERNAL_RESET),
        .RESET_PIN_N_OUT(RESET_PIN_N_OUT), .RESET_PIN_OE(RESET_PIN_OE), .INT_OUT(INT_OUT)
    );
    ioadm_cpu_model u_ioadm_cpu_model (.clk(SYS_CLK), .cpu_valid(CPU_VALID), .cpu_addr(CPU_ADDR));
    // free-running 200 MHz clock
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // apb transfer: request held until the edge that samples ready, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= {a[5:0], 2'b00};
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        check("pready", PREADY, 1'b1);
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask
    task automatic do_reset();
        @(posedge SYS_CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        SRST <= 1'b0;
    endtask
    initial begin
        {SRST, IRQ_PIN_N} = 2'b11;
        {PSEL, PENABLE, PWRITE, INTERNAL_RESET} = 4'h0;
        {PADDR, PWDATA, PORT_A_IN, PORT_B_IN} = {8'h00, 32'h0, 8'hff, 6'h3f};
        repeat (2) @(posedge SYS_CLK);
        SRST <= 1'b0;
        foreach (zero_reg[i]) rd_chk(zero_reg[i], 32'h0);
        $display("test reset_values done");
        wr(IDX_PORT_A_DIR, 8'hff);
        wr(IDX_PORT_A_DATA, 8'ha5);
        rd_chk(IDX_PORT_A_DATA, 32'ha5);
        check("pa_out", PORT_A_OUT, 8'ha5);
        wr(IDX_PORT_B_DIR, 8'hff);
        wr(IDX_PORT_B_DATA, 8'hff);
        rd_chk(IDX_PORT_B_DIR, 32'hbf);
        rd_chk(IDX_PORT_B_DATA, 32'h3f);
        check("pb_oe", PORT_B_OE, 6'h3f);
        check("pb_out", PORT_B_OUT, 6'h3f);
        check("mclk_en", MASTER_CLOCK_OUT_ENABLE, 1'b1);
        wr(IDX_PORT_B_DIR, 8'h00);
        PORT_B_IN <= 6'h15;
        repeat (4) @(posedge SYS_CLK);
        rd_chk(IDX_PORT_B_DATA, 32'h15);
        do_reset();
        rd_chk(IDX_PORT_A_DIR, 32'h0);
        wr(IDX_PORT_A_DIR, 8'hff);
        rd_chk(IDX_PORT_A_DATA, 32'ha5);
        wr(IDX_PORT_B_DIR, 8'h3f);
        rd_chk(IDX_PORT_B_DATA, 32'h3f);
        $display("test ports done");
        wr(IDX_KBD_ENABLE, 8'hff);
        rd_chk(IDX_KBD_ENABLE, 32'h7e);
        check("pullup", PORT_A_PULLUP, 8'h7e);
        check("pa_oe", PORT_A_OE, 8'h81);
        PORT_A_IN <= 8'hfd;
        IRQ_PIN_N <= 1'b0;
        repeat (6) @(posedge SYS_CLK);
        rd_chk(IDX_IRQ_KBD, 32'h88);
        check("irqs", {CPU_IRQ, CPU_KBD_IRQ}, 2'b11);
        rd_chk(IDX_INT_STATUS, 32'h06);
        check("int_masked", INT_OUT, 1'b0);
        wr(IDX_INT_ENABLE, 8'h04);
        @(posedge SYS_CLK);
        check("int_on", INT_OUT, 1'b1);
        PORT_A_IN <= 8'hff;
        IRQ_PIN_N <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        wr(IDX_IRQ_KBD, 8'h44);
        rd_chk(IDX_IRQ_KBD, 32'h0);
        wr(IDX_IRQ_KBD, 8'hff);
        rd_chk(IDX_IRQ_KBD, 32'h33);
        wr(IDX_INT_CLEAR, 8'h06);
        rd_chk(IDX_INT_STATUS, 32'h0);
        check("int_off", INT_OUT, 1'b0);
        rd_chk(IDX_INT_CLEAR, 32'h0);
        apb(1'b0, 8'h02, 32'h0);
        check("pslverr", err, 1'b1);
        $display("test irq_keyboard done");
        foreach (ok_addr[i]) begin
            u_ioadm_cpu_model.access(ok_addr[i], i % 2);
            #1;
            check($sformatf("sel %h", ok_addr[i]), CPU_SEL, ok_sel[i]);
        end
        check("no_illegal", ILLEGAL_RESET_REQ, 1'b0);
        foreach (bad_addr[i]) begin
            u_ioadm_cpu_model.access(bad_addr[i], 0);
            #1;
            check("illegal", {ILLEGAL_RESET_REQ, RESET_PIN_OE, CPU_SEL}, {2'b11, IOADM_SEL_NONE});
            repeat (3) @(posedge SYS_CLK);
            check("held", ILLEGAL_RESET_REQ, 1'b1);
            rd_chk(IDX_LAST_ADDR, {16'h0, bad_addr[i]});
            do_reset();
        end
        @(posedge SYS_CLK);
        INTERNAL_RESET <= 1'b1;
        @(posedge SYS_CLK);
        INTERNAL_RESET <= 1'b0;
        #1;
        check("pin_oe", RESET_PIN_OE, 1'b1);
        $display("test decode done");
        final_report();
    end
endmodule
